//--- core/prgb_consts.svh
// constants of the profile, ram word and gpio register bank
`ifndef PRGB_CONSTS_SVH
`define PRGB_CONSTS_SVH
`define PRGB_ADDR_LAST 5'h19
`define PRGB_ADDR_PROFILE7 5'h15
`define PRGB_ADDR_RAM 5'h16
`define PRGB_ADDR_GPIO_DIR 5'h18
`define PRGB_ADDR_GPIO_VAL 5'h19
`define PRGB_ADDR_HOLE_A0 5'h07
`define PRGB_ADDR_HOLE_A1 5'h08
`define PRGB_ADDR_HOLE_B0 5'h0B
`define PRGB_ADDR_HOLE_B1 5'h0D
`define PRGB_ADDR_HOLE_C 5'h17
`define PRGB_LEN_PROFILE 4'h8
`define PRGB_LEN_RAM 4'h4
`define PRGB_LEN_GPIO 4'h2
`define PRGB_LEN_NONE 4'h0
`define PRGB_RST_PROFILE 64'h0000000000000000
`define PRGB_RST_RAM 32'h00000000
`define PRGB_RST_GPIO 16'h0000
`define PRGB_ST_OPEN_MASK 64'h3FFFFFFFFFFFFFFF
`define PRGB_ST_AMP_HI 61
`define PRGB_ST_AMP_LO 48
`define PRGB_PHASE_HI 47
`define PRGB_PHASE_LO 32
`define PRGB_FTW_HI 31
`define PRGB_FTW_LO 0
`define PRGB_QD_RATE_HI 63
`define PRGB_QD_RATE_LO 58
`define PRGB_QD_INVERT 57
`define PRGB_QD_BYPASS 56
`define PRGB_QD_SCALE_HI 55
`define PRGB_QD_SCALE_LO 48
`endif

//--- core/prgb_pkg.sv
// types shared by the register bank
package prgb_pkg;
	// operating mode codes; 2'b11 behaves as interpolating converter
	typedef enum logic [1:0]
	{
		PRGB_MODE_QUAD = 2'b00,
		PRGB_MODE_TONE = 2'b01,
		PRGB_MODE_INTERP = 2'b10
	} prgb_mode_t;
endpackage

//--- core/prgb_sync.sv
// two-flop synchroniser for asynchronous pin levels
module prgb_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_r; // first stage, read only by the second

	// plain double register against metastability
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			meta_r <= '0;
			q <= '0;
		end
		else
		begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule

//--- core/prgb_bank.sv
// profile seven, ram word and gpio register bank with update buffering
`include "prgb_consts.svh"
module prgb_bank
	import prgb_pkg::*;
#(
	parameter logic [3:0] OTHER_LEN = 4'h4 // length of registers kept elsewhere
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [4:0] acc_addr,
	input wire logic acc_wr,
	input wire logic acc_rd,
	input wire logic [63:0] acc_wdata,
	input wire logic [1:0] op_mode,
	input wire logic io_update_pin,
	input wire logic [2:0] profile_pin,
	output logic [63:0] rd_data_r,
	output logic rd_valid_r,
	output logic [3:0] acc_len_r,
	output logic acc_impl_r,
	output logic acc_local_r,
	output logic layout_quad_r,
	output logic [63:0] profile_act_r,
	output logic [31:0] ram_act_r,
	output logic [15:0] gpio_dir_act_r,
	output logic [15:0] gpio_val_act_r
);
	// true when the address holds one of the twenty registers
	function automatic logic is_impl(input logic [4:0] a);
		logic hole;
		hole = (a == `PRGB_ADDR_HOLE_A0) || (a == `PRGB_ADDR_HOLE_A1) ||
			((a >= `PRGB_ADDR_HOLE_B0) && (a <= `PRGB_ADDR_HOLE_B1)) ||
			(a == `PRGB_ADDR_HOLE_C);
		return (a <= `PRGB_ADDR_LAST) && !hole;
	endfunction

	// byte count that a serial transfer at this address carries
	function automatic logic [3:0] reg_len(input logic [4:0] a);
		logic [3:0] n;
		n = `PRGB_LEN_NONE;
		if (a == `PRGB_ADDR_PROFILE7)
			n = `PRGB_LEN_PROFILE;
		else if (a == `PRGB_ADDR_RAM)
			n = `PRGB_LEN_RAM;
		else if ((a == `PRGB_ADDR_GPIO_DIR) || (a == `PRGB_ADDR_GPIO_VAL))
			n = `PRGB_LEN_GPIO;
		else if (is_impl(a))
			n = OTHER_LEN;
		return n;
	endfunction

	logic [63:0] profile_buf_r; // serial-side copy of profile seven
	logic [31:0] ram_buf_r; // serial-side ram word
	logic [15:0] gpio_dir_buf_r; // serial-side gpio direction
	logic [15:0] gpio_val_buf_r; // serial-side gpio values
	logic upd_s; // synchronised update level
	logic upd_d_r; // previous update level for edge detect
	logic [2:0] prof_s; // synchronised profile select
	logic [2:0] prof_d_r; // previous profile select
	logic prof_armed_r; // holds change detect off right after reset

	// pins cross into the core clock before anything looks at them
	prgb_sync #(.W(1)) u_upd_sync (
		.clk(clk),
		.rst(rst),
		.d(io_update_pin),
		.q(upd_s)
	);
	prgb_sync #(.W(3)) u_prof_sync (
		.clk(clk),
		.rst(rst),
		.d(profile_pin),
		.q(prof_s)
	);

	// decode of the current access
	wire addr_impl = is_impl(acc_addr);
	wire hit_prof = acc_addr == `PRGB_ADDR_PROFILE7;
	wire hit_ram = acc_addr == `PRGB_ADDR_RAM;
	wire hit_dir = acc_addr == `PRGB_ADDR_GPIO_DIR;
	wire hit_val = acc_addr == `PRGB_ADDR_GPIO_VAL;
	wire hit_local = hit_prof | hit_ram | hit_dir | hit_val;
	wire [3:0] len_nxt = reg_len(acc_addr);

	// mode decode; the top code also means interpolating converter
	wire mode_quad = op_mode == PRGB_MODE_QUAD;
	wire mode_tone = op_mode == PRGB_MODE_TONE;

	// open top bits of the tone layout are dropped so they read zero
	wire [63:0] prof_wmask = mode_tone ? `PRGB_ST_OPEN_MASK : ~64'h0;
	wire [63:0] prof_wval = acc_wdata & prof_wmask;

	// transfer moments: update rising edge or any profile pin change
	wire upd_edge = upd_s & ~upd_d_r;
	wire prof_change = prof_armed_r & (prof_s != prof_d_r);
	wire xfer = upd_edge | prof_change;

	// read selection over the serial-side copies
	wire [63:0] rd_nxt = hit_prof ? profile_buf_r :
		hit_ram ? {32'h0, ram_buf_r} :
		hit_dir ? {48'h0, gpio_dir_buf_r} :
		hit_val ? {48'h0, gpio_val_buf_r} : 64'h0;

	// edge detect history; first cycle after reset never counts as change
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			upd_d_r <= 1'b0;
			prof_d_r <= 3'h0;
			prof_armed_r <= 1'b0;
		end
		else
		begin
			upd_d_r <= upd_s;
			prof_d_r <= prof_s;
			prof_armed_r <= 1'b1;
		end
	end

	// buffer stage: serial writes land here only
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			profile_buf_r <= `PRGB_RST_PROFILE;
			ram_buf_r <= `PRGB_RST_RAM;
			gpio_dir_buf_r <= `PRGB_RST_GPIO;
			gpio_val_buf_r <= `PRGB_RST_GPIO;
		end
		else if (acc_wr)
		begin
			// unimplemented addresses fall through with no storage
			if (hit_prof)
				profile_buf_r <= prof_wval;
			if (hit_ram)
				ram_buf_r <= acc_wdata[31:0];
			if (hit_dir)
				gpio_dir_buf_r <= acc_wdata[15:0];
			if (hit_val)
				gpio_val_buf_r <= acc_wdata[15:0];
		end
	end

	// active stage: a write in the same cycle as a transfer waits for the next
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			profile_act_r <= `PRGB_RST_PROFILE;
			ram_act_r <= `PRGB_RST_RAM;
			gpio_dir_act_r <= `PRGB_RST_GPIO;
			gpio_val_act_r <= `PRGB_RST_GPIO;
		end
		else if (xfer)
		begin
			profile_act_r <= profile_buf_r;
			ram_act_r <= ram_buf_r;
			gpio_dir_act_r <= gpio_dir_buf_r;
			gpio_val_act_r <= gpio_val_buf_r;
		end
	end

	// access answers and layout flag, one cycle behind the request
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			rd_data_r <= 64'h0;
			rd_valid_r <= 1'b0;
			acc_len_r <= `PRGB_LEN_NONE;
			acc_impl_r <= 1'b0;
			acc_local_r <= 1'b0;
			layout_quad_r <= 1'b1;
		end
		else
		begin
			rd_valid_r <= acc_rd;
			if (acc_rd)
				rd_data_r <= rd_nxt;
			acc_len_r <= len_nxt;
			acc_impl_r <= addr_impl;
			acc_local_r <= hit_local;
			layout_quad_r <= mode_quad;
		end
	end

	// a profile seven write while the quadrature layout applies
	sequence s_prof_write;
		acc_wr && hit_prof && mode_quad;
	endsequence

	property p_len_profile;
		@(posedge clk) disable iff (rst)
		(acc_addr == `PRGB_ADDR_PROFILE7) |=> (acc_len_r == `PRGB_LEN_PROFILE);
	endproperty
	a_len_profile: assert property (p_len_profile)
		else $error("profile length is not eight bytes");

	property p_hole_zero;
		@(posedge clk) disable iff (rst)
		(acc_rd && !is_impl(acc_addr)) |=>
			(rd_valid_r && rd_data_r == 64'h0 && !acc_impl_r);
	endproperty
	a_hole_zero: assert property (p_hole_zero)
		else $error("unimplemented address returned data");

	property p_range;
		@(posedge clk) disable iff (rst)
		(acc_addr > `PRGB_ADDR_LAST) |=>
			!acc_impl_r && acc_len_r == `PRGB_LEN_NONE;
	endproperty
	a_range: assert property (p_range)
		else $error("address beyond range decoded");

	property p_hold;
		@(posedge clk) disable iff (rst)
		!xfer |=> $stable(profile_act_r) && $stable(ram_act_r);
	endproperty
	a_hold: assert property (p_hold)
		else $error("active value moved without update");

	property p_load;
		@(posedge clk) disable iff (rst)
		xfer |=> profile_act_r == $past(profile_buf_r) &&
			gpio_val_act_r == $past(gpio_val_buf_r);
	endproperty
	a_load: assert property (p_load)
		else $error("update did not load buffered value");

	property p_quad_fields;
		@(posedge clk) disable iff (rst)
		s_prof_write ##1 (!acc_wr && !xfer)[*2] |->
			profile_buf_r[`PRGB_QD_RATE_HI:`PRGB_QD_RATE_LO] ==
			$past(acc_wdata[`PRGB_QD_RATE_HI:`PRGB_QD_RATE_LO], 2);
	endproperty
	a_quad_fields: assert property (p_quad_fields)
		else $error("quadrature rate field not kept");

	property p_mode_flag;
		@(posedge clk) disable iff (rst)
		(op_mode == PRGB_MODE_TONE) |=> !layout_quad_r;
	endproperty
	a_mode_flag: assert property (p_mode_flag)
		else $error("tone mode shows quadrature layout");

	property p_tone_open;
		@(posedge clk) disable iff (rst)
		(acc_wr && hit_prof && mode_tone) |=>
			(profile_buf_r & ~`PRGB_ST_OPEN_MASK) == 64'h0;
	endproperty
	a_tone_open: assert property (p_tone_open)
		else $error("open tone bits stored");
endmodule

//--- bench/prgb_host.sv
// host model driving the register access port and the update pins
module prgb_host
(
	input wire logic clk,
	output logic [4:0] acc_addr,
	output logic acc_wr,
	output logic acc_rd,
	output logic [63:0] acc_wdata,
	output logic io_update_pin,
	output logic [2:0] profile_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	// idle levels from time zero
	initial
	begin
		acc_addr = 5'h00;
		acc_wr = 1'b0;
		acc_rd = 1'b0;
		acc_wdata = 64'h0;
		io_update_pin = 1'b0;
		profile_pin = 3'h0;
	end
	// whole register in one strobe; data inverted once released
	task automatic wr(input logic [4:0] a, input logic [63:0] d);
		@(posedge clk);
		acc_addr <= a;
		acc_wdata <= d;
		acc_wr <= 1'b1;
		@(posedge clk);
		acc_wr <= 1'b0;
		acc_wdata <= ~d;
	endtask
	// read strobe; the answer lands on the edge where this returns
	task automatic rd(input logic [4:0] a);
		@(posedge clk);
		acc_addr <= a;
		acc_rd <= 1'b1;
		@(posedge clk);
		acc_rd <= 1'b0;
	endtask
	// update pulse long enough for the synchroniser, then a low gap
	task automatic upd();
		@(posedge clk);
		io_update_pin <= 1'b1;
		repeat (2) @(posedge clk);
		io_update_pin <= 1'b0;
		repeat (5) @(posedge clk);
	endtask
	// profile pin change also moves buffers into the active set
	task automatic prof();
		@(posedge clk);
		profile_pin <= profile_pin + 3'h1;
		repeat (7) @(posedge clk);
	endtask
endmodule

//--- bench/tb_profile_ram_gpio_register_bank.sv
// self-checking bench of the profile, ram and gpio register bank
module tb_profile_ram_gpio_register_bank;
	import prgb_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [1:0] op_mode = PRGB_MODE_QUAD;
	logic [4:0] acc_addr;
	logic acc_wr, acc_rd, io_update_pin, rd_valid_r, acc_impl_r;
	logic [63:0] acc_wdata, rd_data_r, profile_act_r;
	logic [2:0] profile_pin;
	logic [3:0] acc_len_r;
	logic layout_quad_r;
	logic [31:0] ram_act_r;
	logic [15:0] gpio_dir_act_r, gpio_val_act_r;
	logic [63:0] d;
	logic [15:0] g;
	logic [31:0] r;
	logic acc_local_r;
	// model of the serial-side copies: profile, ram, gpio dir, gpio values
	logic [63:0] m_buf [4] = '{default: 64'h0};
	// model of the active set, refreshed at each transfer
	logic [63:0] m_act [4] = '{default: 64'h0};
	int miscompares = 0;
	int check_count = 0;
	int seed;
	// 200 MHz core clock
	always #2.5 clk = ~clk;
	prgb_bank prgb_bank_inst (.clk(clk), .rst(rst), .acc_addr(acc_addr),
		.acc_wr(acc_wr), .acc_rd(acc_rd), .acc_wdata(acc_wdata),
		.op_mode(op_mode), .io_update_pin(io_update_pin),
		.profile_pin(profile_pin), .rd_data_r(rd_data_r),
		.rd_valid_r(rd_valid_r), .acc_len_r(acc_len_r),
		.acc_impl_r(acc_impl_r), .acc_local_r(acc_local_r),
		.layout_quad_r(layout_quad_r), .profile_act_r(profile_act_r),
		.ram_act_r(ram_act_r), .gpio_dir_act_r(gpio_dir_act_r),
		.gpio_val_act_r(gpio_val_act_r));
	prgb_host prgb_host_inst (.clk(clk), .acc_addr(acc_addr),
		.acc_wr(acc_wr), .acc_rd(acc_rd), .acc_wdata(acc_wdata),
		.io_update_pin(io_update_pin), .profile_pin(profile_pin));
	// expected byte length; zero marks a hole or an out-of-range slot
	function automatic logic [3:0] elen(input int a);
		if (a > 25 || a == 7 || a == 8 || a == 23 || (a > 10 && a < 14))
			return 4'h0;
		if (a == 21)
			return 4'h8;
		if (a == 22)
			return 4'h4;
		return (a > 23) ? 4'h2 : 4'h4;
	endfunction
	// one comparison, counted; four-state equality
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		check_count++;
		if (got !== exp)
		begin
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
			miscompares++;
		end
	endtask
	// model slot of a locally held address, -1 elsewhere
	function automatic int slot(input int a);
		if (a == 21)
			return 0;
		if (a == 22)
			return 1;
		if (a == 24 || a == 25)
			return a - 22;
		return -1;
	endfunction
	// write through the host and into the model; tone drops open bits
	task automatic mwr(input int a, input logic [63:0] v);
		int s;
		s = slot(a);
		prgb_host_inst.wr(a[4:0], v);
		if (s == 0 && op_mode == PRGB_MODE_TONE)
			v[63:62] = 2'b00;
		if (s == 1)
			v = {32'h0, v[31:0]};
		if (s > 1)
			v = {48'h0, v[15:0]};
		if (s >= 0)
			m_buf[s] = v;
	endtask
	// all four active registers against the model
	task automatic cmp_act();
		chk(profile_act_r, m_act[0]);
		chk({32'h0, ram_act_r}, m_act[1]);
		chk({48'h0, gpio_dir_act_r}, m_act[2]);
		chk({48'h0, gpio_val_act_r}, m_act[3]);
	endtask
	// counts, verdict, stop
	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// hang guard, well past the expected run
	initial
	begin
		#20000;
		miscompares++;
		end_sim();
	end
	// main sequence
	initial
	begin
		seed = $urandom(32'hC5F3);
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		#1;
		chk(profile_act_r, 64'h0);
		chk({63'h0, layout_quad_r}, 64'h1);
		// sweep all slots: length, presence, empty read
		for (int a = 0; a < 32; a++)
		begin
			prgb_host_inst.rd(a[4:0]);
			#1;
			chk({60'h0, acc_len_r}, {60'h0, elen(a)});
			chk({63'h0, acc_impl_r}, {63'h0, elen(a) != 4'h0});
			chk({rd_valid_r, rd_data_r}, {1'b1, 64'h0});
			chk({63'h0, acc_local_r}, {63'h0, slot(a) >= 0});
		end
		// buffered write shows on read, active waits for update
		d = {$urandom, $urandom};
		g = 16'($urandom);
		r = $urandom;
		mwr(25, {48'h0, g});
		mwr(22, {32'h0, r});
		mwr(24, {48'h0, ~g});
		mwr(23, d);
		mwr(21, d);
		prgb_host_inst.rd(5'h15);
		#1;
		chk(rd_data_r, m_buf[0]);
		cmp_act();
		prgb_host_inst.rd(5'h17);
		#1;
		chk(rd_data_r, 64'h0);
		prgb_host_inst.upd();
		#1;
		m_act = m_buf;
		cmp_act();
		chk({58'h0, profile_act_r[63:58]}, {58'h0, d[63:58]});
		// tone layout drops the two open top bits
		@(posedge clk);
		op_mode <= PRGB_MODE_TONE;
		d = {$urandom, $urandom};
		mwr(21, d);
		prgb_host_inst.prof();
		#1;
		m_act = m_buf;
		cmp_act();
		chk(profile_act_r, {2'b00, d[61:0]});
		// every mode code against the layout flag
		for (int m = 0; m < 4; m++)
		begin
			@(posedge clk);
			op_mode <= m[1:0];
			repeat (2) @(posedge clk);
			#1;
			chk({63'h0, layout_quad_r}, {63'h0, m == 0});
		end
		end_sim();
	end
endmodule
